// ---- design/hcip_pkg.sv ----
// package: register map, fields and carriers of the host command/interrupt port
package hcip_pkg;
  localparam logic [1:0] HCIP_OFS_CTRL_STATUS = 2'h0;
  localparam logic [1:0] HCIP_OFS_CMD_REPLY   = 2'h1;
  localparam logic [1:0] HCIP_OFS_CAUSE       = 2'h2;
  // status bit positions
  localparam int HCIP_ST_CMD_INVALID = 0;
  localparam int HCIP_ST_REPLY_VALID = 2;
  localparam int HCIP_ST_PORT_BUSY   = 3;
  localparam int HCIP_ST_IDLE        = 4;
  // control bit positions
  localparam int HCIP_CT_ACK         = 5;
  localparam int HCIP_CT_ABORT       = 6;
  localparam int HCIP_CT_HARD        = 7;
  // cause bit positions
  localparam int HCIP_CA_INBOUND     = 0;
  localparam int HCIP_CA_OUTBOUND    = 1;
  localparam int HCIP_CA_DONE        = 2;
  localparam int HCIP_CA_BUSRST      = 3;
  localparam int HCIP_CA_PENDING     = 7;
  localparam logic [7:0] HCIP_RST_BYTE = 8'h00;
  localparam logic [3:0] HCIP_RST_LATCH = 4'h0;
  localparam int HCIP_FIFO_DEPTH = 4;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [1:0] addr;
    logic [7:0] wdata;
  } hcip_host_s;

  typedef struct packed {
    logic inbound_filled;
    logic outbound_cleared;
    logic command_done;
    logic command_failed;
    logic bus_reset;
  } hcip_event_s;
endpackage

// ---- design/hcip_fifo.sv ----
// small valid/ready fifo for reply bytes
`timescale 1ns/1ps
`default_nettype none
module hcip_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             flush,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr_reg;
  logic [AW-1:0]    rptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      count_reg <= '0;
    end else if (flush) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= (wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= (rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- design/hcip_port.sv ----
// host command/parameter, reply and interrupt cause port
//
// Contract
// - write-only command byte port at offset 1
// - host command write sets busy flag
// - local processor take clears busy flag
// - wrong byte count flags command invalid
// - all command bytes sent sets done cause
// - detected command error sets invalid flag
// - reply valid set while reply bytes queued; host read of the last queued byte clears it
// - last reply byte read sets done
// - interrupt sets pending bit7 plus cause
// - cause bits 0..3 fixed, 4..6 zero
// - resets clear the cause register
// - mailbox causes withheld behind done/busreset
// - done/busreset shown only when clear, no reply
// - outbound free only if enabled and cleared
// - inbound slots filled round robin
// - done alone normal; with invalid failed
// - pending bit follows interrupt line level
// - abort bit drops queued work, needs reinit
// - acknowledge bit5 clears cause and line
// - status bits 0,2,3,4 at offset 0
`timescale 1ns/1ps
`default_nettype none
module hcip_port
  import hcip_pkg::*;
#(
  parameter int FIFO_DEPTH   = hcip_pkg::HCIP_FIFO_DEPTH,
  parameter int INBOUND_SLOTS = 4
) (
  // clock and reset
  input  wire logic                           clk_sys,
  input  wire logic                           rstn,
  // host i/o bus, one byte access per cycle strobe
  input  wire hcip_pkg::hcip_host_s           host_bus,
  output logic [7:0]                          host_rdata,
  output logic                                host_irq,
  // local processor command side
  output logic                                lp_cmd_valid,
  output logic [7:0]                          lp_cmd_byte,
  input  wire logic                           lp_cmd_take,
  input  wire logic                           lp_cmd_last,
  input  wire logic                           lp_cmd_error,
  // local processor reply side
  input  wire logic                           lp_reply_valid,
  output logic                                lp_reply_ready,
  input  wire logic [7:0]                     lp_reply_byte,
  input  wire logic                           lp_reply_last,
  // local processor status and events
  input  wire logic                           lp_idle,
  input  wire logic                           lp_outbound_irq_en,
  input  wire hcip_pkg::hcip_event_s          lp_event,
  output logic [$clog2(INBOUND_SLOTS)-1:0]    lp_inbound_slot,
  output logic                                lp_abort,
  output logic                                lp_hard_reset
);
  import hcip_pkg::*;

  localparam int SW = $clog2(INBOUND_SLOTS);

  logic [7:0]  cmd_reg;
  logic        busy_reg;
  logic        invalid_reg;
  logic [7:0]  cause_reg;
  logic        lat_inbound_reg;
  logic        lat_outbound_reg;
  logic        lat_done_reg;
  logic        lat_busrst_reg;
  logic [SW-1:0] slot_reg;
  logic        abort_reg;
  logic        hard_reg;
  logic [7:0]  rdata_next;
  logic        host_wr_cmd;
  logic        host_wr_ctrl;
  logic        host_rd_reply;
  logic        ack;
  logic        reply_valid;
  logic [7:0]  reply_data;
  logic        fifo_in_ready;
  logic        last_in;
  logic        last_out;
  logic        post_priority;
  logic        post_mailbox;
  logic        cause_clear;
  logic        post_busrst;
  logic        post_done;
  logic        post_inbound;
  logic        post_outbound;

  // single-access byte decode
  assign host_wr_cmd   = host_bus.wr && (host_bus.addr == HCIP_OFS_CMD_REPLY);
  assign host_wr_ctrl  = host_bus.wr && (host_bus.addr == HCIP_OFS_CTRL_STATUS);
  assign host_rd_reply = host_bus.rd && (host_bus.addr == HCIP_OFS_CMD_REPLY) && reply_valid;
  assign ack           = host_wr_ctrl && host_bus.wdata[HCIP_CT_ACK];
  assign cause_clear   = !cause_reg[HCIP_CA_PENDING];

  // reply bytes travel with a last mark through the fifo
  hcip_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_reply_fifo (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .flush     (abort_reg),
    .in_valid  (lp_reply_valid),
    .in_ready  (fifo_in_ready),
    .in_data   ({lp_reply_last, lp_reply_byte}),
    .out_valid (reply_valid),
    .out_ready (host_rd_reply),
    .out_data  ({last_out, reply_data})
  );
  assign lp_reply_ready = fifo_in_ready;
  assign last_in        = host_rd_reply && last_out;

  // command byte holding register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cmd_reg <= HCIP_RST_BYTE;
    end else if (host_wr_cmd && !busy_reg && !abort_reg) begin
      cmd_reg <= host_bus.wdata;
    end
  end

  // busy handshake: host write sets, local take clears
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy_reg <= 1'b0;
    end else if (abort_reg) begin
      busy_reg <= 1'b0;
    end else if (host_wr_cmd && !busy_reg) begin
      busy_reg <= 1'b1;
    end else if (lp_cmd_take) begin
      busy_reg <= 1'b0;
    end
  end
  assign lp_cmd_valid = busy_reg;
  assign lp_cmd_byte  = cmd_reg;

  // command invalid flag, cleared by abort or by the next new command byte while lp_idle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      invalid_reg <= 1'b0;
    end else if (lp_cmd_error || lp_event.command_failed) begin
      invalid_reg <= 1'b1;
    end else if (abort_reg || (host_wr_cmd && !busy_reg && lp_idle)) begin
      invalid_reg <= 1'b0;
    end
  end

  // inbound mailbox latch; set wins over posting
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lat_inbound_reg <= 1'b0;
    end else if (abort_reg) begin
      lat_inbound_reg <= 1'b0;
    end else if (lp_event.inbound_filled) begin
      lat_inbound_reg <= 1'b1;
    end else if (post_inbound) begin
      lat_inbound_reg <= 1'b0;
    end
  end

  // outbound slot free latch, only while enabled
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lat_outbound_reg <= 1'b0;
    end else if (abort_reg) begin
      lat_outbound_reg <= 1'b0;
    end else if (lp_event.outbound_cleared && lp_outbound_irq_en) begin
      lat_outbound_reg <= 1'b1;
    end else if (post_outbound) begin
      lat_outbound_reg <= 1'b0;
    end
  end

  // command done latch: last byte taken, done event or last reply read
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lat_done_reg <= 1'b0;
    end else if (abort_reg) begin
      lat_done_reg <= 1'b0;
    end else if ((lp_cmd_take && lp_cmd_last) || lp_event.command_done || last_in) begin
      lat_done_reg <= 1'b1;
    end else if (post_done) begin
      lat_done_reg <= 1'b0;
    end
  end

  // bus reset latch
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lat_busrst_reg <= 1'b0;
    end else if (abort_reg) begin
      lat_busrst_reg <= 1'b0;
    end else if (lp_event.bus_reset) begin
      lat_busrst_reg <= 1'b1;
    end else if (post_busrst) begin
      lat_busrst_reg <= 1'b0;
    end
  end

  // done/busreset need clear register and no reply waiting; mailbox waits behind them
  assign post_priority = cause_clear && !ack && !reply_valid && !last_in
                         && (lat_done_reg || lat_busrst_reg);
  assign post_mailbox  = cause_clear && !ack && !post_priority
                         && !lat_done_reg && !lat_busrst_reg
                         && (lat_inbound_reg || lat_outbound_reg);

  // one cause per interrupt: bus reset before done, inbound before outbound
  assign post_busrst   = post_priority && lat_busrst_reg;
  assign post_done     = post_priority && !lat_busrst_reg;
  assign post_inbound  = post_mailbox && lat_inbound_reg;
  assign post_outbound = post_mailbox && !lat_inbound_reg;

  // interrupt cause register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cause_reg <= HCIP_RST_BYTE;
    end else if (abort_reg || ack) begin
      cause_reg <= HCIP_RST_BYTE;
    end else if (post_priority) begin
      cause_reg[HCIP_CA_PENDING] <= 1'b1;
      cause_reg[HCIP_CA_DONE]    <= post_done;
      cause_reg[HCIP_CA_BUSRST]  <= post_busrst;
    end else if (post_mailbox) begin
      cause_reg[HCIP_CA_PENDING]  <= 1'b1;
      cause_reg[HCIP_CA_INBOUND]  <= post_inbound;
      cause_reg[HCIP_CA_OUTBOUND] <= post_outbound;
    end
  end
  assign host_irq = cause_reg[HCIP_CA_PENDING];

  // inbound slot pointer advances round robin per fill
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      slot_reg <= '0;
    end else if (abort_reg) begin
      slot_reg <= '0;
    end else if (lp_event.inbound_filled) begin
      slot_reg <= (slot_reg == SW'(INBOUND_SLOTS-1)) ? '0 : slot_reg + 1'b1;
    end
  end
  assign lp_inbound_slot = slot_reg;

  // abort pulse on soft or hard reset request; clears itself
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      abort_reg <= 1'b0;
    end else begin
      abort_reg <= host_wr_ctrl && (host_bus.wdata[HCIP_CT_ABORT] || host_bus.wdata[HCIP_CT_HARD]);
    end
  end

  // hard reset pulse; clears itself
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hard_reg <= 1'b0;
    end else begin
      hard_reg <= host_wr_ctrl && host_bus.wdata[HCIP_CT_HARD];
    end
  end
  assign lp_abort      = abort_reg;
  assign lp_hard_reset = hard_reg;

  // read data mux
  always_comb begin
    rdata_next = HCIP_RST_BYTE;
    case (host_bus.addr)
      HCIP_OFS_CTRL_STATUS: begin
        rdata_next[HCIP_ST_CMD_INVALID] = invalid_reg;
        rdata_next[HCIP_ST_REPLY_VALID] = reply_valid;
        rdata_next[HCIP_ST_PORT_BUSY]   = busy_reg;
        rdata_next[HCIP_ST_IDLE]        = lp_idle;
      end
      HCIP_OFS_CMD_REPLY: begin
        rdata_next = reply_valid ? reply_data : HCIP_RST_BYTE;
      end
      HCIP_OFS_CAUSE: begin
        rdata_next = cause_reg;
      end
      default: begin
        rdata_next = HCIP_RST_BYTE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      host_rdata <= HCIP_RST_BYTE;
    end else if (host_bus.rd) begin
      host_rdata <= rdata_next;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/hcip_port_asserts.sv ----
// checker: host port assertions
`timescale 1ns/1ps
`default_nettype none
module hcip_port_asserts (
  // clock and reset
  input wire logic                 clk_sys,
  input wire logic                 rstn,
  // host side
  input wire hcip_pkg::hcip_host_s host_bus,
  input wire logic [7:0]           host_rdata,
  input wire logic                 host_irq,
  // local side
  input wire logic                 lp_cmd_valid,
  input wire logic [7:0]           lp_cmd_byte,
  input wire logic                 lp_cmd_take,
  input wire logic                 lp_idle,
  input wire logic                 lp_abort
);
  import hcip_pkg::*;
  logic wc, wa, rs, rc, ru;
  assign wc = host_bus.wr && host_bus.addr == HCIP_OFS_CMD_REPLY;
  assign wa = host_bus.wr && host_bus.addr == HCIP_OFS_CTRL_STATUS;
  assign rs = host_bus.rd && host_bus.addr == HCIP_OFS_CTRL_STATUS;
  assign rc = host_bus.rd && host_bus.addr == HCIP_OFS_CAUSE;
  assign ru = host_bus.rd && host_bus.addr == 2'h3;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_busy_set; wc && !lp_cmd_valid |=> lp_cmd_valid && lp_cmd_byte == $past(host_bus.wdata); endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not set by command write");
  property p_busy_clr; lp_cmd_valid && lp_cmd_take |=> !lp_cmd_valid; endproperty
  a_busy_clr: assert property (p_busy_clr) else $error("busy not cleared by take");
  property p_status;
    rs |=> host_rdata[3] == $past(lp_cmd_valid) && host_rdata[4] == $past(lp_idle) && host_rdata[7:5] == 3'h0;
  endproperty
  a_status: assert property (p_status) else $error("status byte wrong");
  property p_irq_bit; rc |=> host_rdata[7] == $past(host_irq); endproperty
  a_irq_bit: assert property (p_irq_bit) else $error("pending bit differs from irq line");
  property p_cause_fmt;
    rc |=> host_rdata[6:4] == 3'h0 && (host_rdata[7] ? $onehot(host_rdata[3:0]) : host_rdata[3:0] == 4'h0);
  endproperty
  a_cause_fmt: assert property (p_cause_fmt) else $error("cause byte malformed");
  property p_ack; wa && host_bus.wdata[HCIP_CT_ACK] |=> !host_irq; endproperty
  a_ack: assert property (p_ack) else $error("irq kept after acknowledge");
  property p_hold; host_irq && !(wa && |host_bus.wdata[7:5]) && !lp_abort |=> host_irq; endproperty
  a_hold: assert property (p_hold) else $error("irq dropped without acknowledge");
  property p_unmapped; ru |=> host_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind hcip_port hcip_port_asserts i_chk (.clk_sys(clk_sys), .rstn(rstn), .host_bus(host_bus),
  .host_rdata(host_rdata), .host_irq(host_irq), .lp_cmd_valid(lp_cmd_valid), .lp_cmd_byte(lp_cmd_byte),
  .lp_cmd_take(lp_cmd_take), .lp_idle(lp_idle), .lp_abort(lp_abort));
`default_nettype wire

// ---- testbench/hcip_host_model.sv ----
// host processor model: byte accesses, polling and interrupt service
`timescale 1ns/1ps
`default_nettype none
module hcip_host_model (
  // clock
  input  wire logic                clk_sys,
  // host bus
  output var hcip_pkg::hcip_host_s host_bus,
  input  wire logic [7:0]          host_rdata
);
  import hcip_pkg::*;
  initial host_bus = '0;
  task automatic acc(input logic r, input logic [1:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    host_bus <= '{rd: r, wr: !r, addr: a, wdata: d};
    @(posedge clk_sys);
    host_bus <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    #1 q = host_rdata;
  endtask
  // status bit wait, bounded
  task automatic poll(input int n, input logic v, output logic ok);
    logic [7:0] q;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      acc(1'b1, HCIP_OFS_CTRL_STATUS, 8'h00, q);
      ok = (q[n] === v);
    end
  endtask
  task automatic service(output logic [7:0] c);
    logic [7:0] q;
    acc(1'b1, HCIP_OFS_CAUSE, 8'h00, c);
    acc(1'b0, HCIP_OFS_CTRL_STATUS, 8'h20, q);
  endtask
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking bench of the host command/interrupt port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import hcip_pkg::*;
  logic        clk_sys, rstn, host_irq, lp_cmd_valid, lp_cmd_take, lp_cmd_last, lp_cmd_error, ok;
  logic        lp_reply_valid, lp_reply_ready, lp_reply_last, lp_idle, lp_outbound_irq_en, lp_abort, lp_hard_reset;
  logic [7:0]  host_rdata, lp_cmd_byte, lp_reply_byte, q;
  logic [1:0]  lp_inbound_slot;
  hcip_host_s  host_bus;
  hcip_event_s lp_event;
  logic [15:0] rnd = 16'h5373;
  int          error_cnt = 0, num_checks = 0, nslot = 0;
  logic [7:0]  rq[$];
  logic [4:0]  ev_t[5] = '{5'h10, 5'h08, 5'h08, 5'h04, 5'h01};
  logic [7:0]  ca_t[5] = '{8'h81, 8'h00, 8'h82, 8'h84, 8'h88};
  hcip_port i_dut (.clk_sys, .rstn, .host_bus, .host_rdata, .host_irq, .lp_cmd_valid, .lp_cmd_byte, .lp_cmd_take,
    .lp_cmd_last, .lp_cmd_error, .lp_reply_valid, .lp_reply_ready, .lp_reply_byte, .lp_reply_last, .lp_idle,
    .lp_outbound_irq_en, .lp_event, .lp_inbound_slot, .lp_abort, .lp_hard_reset);
  hcip_host_model i_host (.clk_sys, .host_bus, .host_rdata);
  function automatic logic [15:0] lfsr_f(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_pin(input logic [7:0] g, input logic [7:0] e);
    chk_reg(g, e);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic ev(input logic [4:0] e);
    @(posedge clk_sys);
    lp_event <= e;
    @(posedge clk_sys);
    lp_event <= '0;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic take(input logic last, input logic err);
    @(posedge clk_sys);
    {lp_cmd_take, lp_cmd_last, lp_cmd_error} <= {1'b1, last, err};
    @(posedge clk_sys);
    {lp_cmd_take, lp_cmd_last, lp_cmd_error} <= 3'h0;
    repeat (3) @(posedge clk_sys);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    #100000;
    error_cnt++;
    end_sim;
  end
  initial begin
    rstn = 1'b0;
    {lp_cmd_take, lp_cmd_last, lp_cmd_error, lp_reply_valid, lp_reply_last, lp_outbound_irq_en} = 6'h00;
    lp_idle = 1'b1;
    lp_reply_byte = 8'h00;
    lp_event = '0;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    i_host.acc(1'b1, HCIP_OFS_CAUSE, 8'h00, q);
    chk_reg(q, 8'h00);
    for (int c = 0; c < 2; c++) begin
      for (int j = 0; j < 2; j++) begin
        rnd = lfsr_f(rnd);
        i_host.poll(HCIP_ST_IDLE, 1'b1, ok);
        chk_pin({7'h00, ok}, 8'h01);
        i_host.poll(HCIP_ST_PORT_BUSY, 1'b0, ok);
        chk_pin({7'h00, ok}, 8'h01);
        i_host.acc(1'b0, HCIP_OFS_CMD_REPLY, rnd[7:0], q);
        i_host.acc(1'b0, HCIP_OFS_CMD_REPLY, ~rnd[7:0], q);
        chk_pin(lp_cmd_byte, rnd[7:0]);
        i_host.acc(1'b1, HCIP_OFS_CTRL_STATUS, 8'h00, q);
        chk_reg(q, 8'h18);
        take(j[0], c[0] & j[0]);
        i_host.acc(1'b1, HCIP_OFS_CTRL_STATUS, 8'h00, q);
        chk_reg(q, {7'h08, c[0] & j[0]});
      end
      i_host.service(q);
      chk_reg(q, 8'h84);
    end
    for (int k = 0; k < HCIP_FIFO_DEPTH; k++) begin
      rnd = lfsr_f(rnd);
      @(posedge clk_sys);
      {lp_reply_valid, lp_reply_last, lp_reply_byte} <= {1'b1, k == HCIP_FIFO_DEPTH - 1, rnd[7:0]};
      rq.push_back(rnd[7:0]);
    end
    @(posedge clk_sys);
    {lp_reply_valid, lp_reply_last, lp_reply_byte} <= {2'h0, ~rnd[7:0]};
    #1 chk_pin({7'h00, lp_reply_ready}, 8'h00);
    ev(5'h04);
    i_host.acc(1'b1, HCIP_OFS_CAUSE, 8'h00, q);
    chk_reg(q, 8'h00);
    while (rq.size() > 0) begin
      i_host.poll(HCIP_ST_REPLY_VALID, 1'b1, ok);
      chk_pin({7'h00, ok}, 8'h01);
      i_host.acc(1'b1, HCIP_OFS_CMD_REPLY, 8'h00, q);
      chk_reg(q, rq.pop_front());
    end
    i_host.acc(1'b1, HCIP_OFS_CMD_REPLY, 8'h00, q);
    chk_reg(q, 8'h00);
    i_host.acc(1'b1, HCIP_OFS_CTRL_STATUS, 8'h00, q);
    chk_reg(q, 8'h11);
    i_host.service(q);
    chk_reg(q, 8'h84);
    i_host.acc(1'b1, 2'h3, 8'h00, q);
    chk_reg(q, 8'h00);
    ev(5'h04);
    ev(5'h10);
    nslot++;
    i_host.service(q);
    chk_reg(q, 8'h84);
    repeat (4) @(posedge clk_sys);
    i_host.service(q);
    chk_reg(q, 8'h81);
    for (int t = 0; t < 5; t++) begin
      @(posedge clk_sys);
      lp_outbound_irq_en <= (t == 2);
      ev(ev_t[t]);
      nslot += ev_t[t][4];
      chk_pin({6'h00, lp_inbound_slot}, 8'(nslot % 4));
      i_host.service(q);
      chk_reg(q, ca_t[t]);
    end
    @(posedge clk_sys);
    lp_outbound_irq_en <= 1'b1;
    ev(5'h18);
    i_host.service(q);
    chk_reg(q, 8'h81);
    i_host.service(q);
    chk_reg(q, 8'h82);
    for (int t = 0; t < 2; t++) begin
      ev(5'h01);
      chk_pin({7'h00, host_irq}, 8'h01);
      i_host.acc(1'b0, HCIP_OFS_CTRL_STATUS, t ? 8'h80 : 8'h40, q);
      chk_pin({6'h00, lp_abort, lp_hard_reset}, {6'h00, 1'b1, t[0]});
      repeat (3) @(posedge clk_sys);
      i_host.acc(1'b1, HCIP_OFS_CAUSE, 8'h00, q);
      chk_reg(q, 8'h00);
      chk_pin({6'h00, lp_inbound_slot}, 8'h00);
    end
    end_sim;
  end
endmodule
`default_nettype wire
